// [core/uxf_uart.sv]
`timescale 1ns/100ps
module uxf_uart #(
  parameter int FIFO_W = 8,
  parameter int FIFO_D = uxf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Configuration
  input wire logic [15:0] baud_div,
  input wire logic data_eight,
  input wire uxf_pkg::uxf_par_type par_mode,
  input wire logic stop_two,
  input wire logic sw_flow_en,
  input wire logic hw_flow_en,
  input wire logic [7:0] xoff_char,
  input wire logic [7:0] xon_char,
  input wire logic [7:0] eot_char,
  // Transmit data
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Receive data
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  output logic parity_err,
  output logic frame_err,
  output logic eot_seen,
  output logic tx_halted,
  // Local readiness to accept
  input wire logic local_busy,
  // Serial line and modem
  output logic txd,
  input wire logic rxd,
  output logic dtr,
  output logic rts,
  input wire logic cts,
  input wire logic dsr,
  input wire logic dcd
);
  import uxf_pkg::*;

  // Oversampling tick
  logic [15:0] div_cnt;
  logic tick;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= div_cnt == 16'h0000;
      div_cnt <= (div_cnt == 16'h0000) ? baud_div : div_cnt - 16'h0001;
    end
  end

  // Parity function
  function automatic logic par_bit(input logic [6:0] d, input uxf_par_type m);
    case (m)
      UXF_PAR_EVEN: par_bit = ^d;
      UXF_PAR_ODD: par_bit = ~^d;
      UXF_PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  // Receiver
  uxf_rx_type rx_st;
  logic [3:0] rx_os;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_perr;
  logic rx_done;
  logic rx_ferr;
  wire [2:0] rx_last = data_eight ? 3'h7 : 3'h6;
  wire rx_mid = tick && rx_os == OVS_MID;
  wire [7:0] rx_char = data_eight ? rx_sh : {1'b0, rx_sh[7:1]};
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st <= UXF_RX_IDLE;
      rx_os <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_perr <= 1'b0;
      rx_done <= 1'b0;
      rx_ferr <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (tick) begin
        rx_os <= rx_os + 4'h1;
      end
      case (rx_st)
        UXF_RX_IDLE: begin
          if (!rxd) begin
            rx_st <= UXF_RX_START;
            rx_os <= '0;
          end
        end
        UXF_RX_START: begin
          if (rx_mid) begin
            rx_os <= OVS_MID + 4'h1;
            rx_bit <= '0;
            rx_st <= rxd ? UXF_RX_IDLE : UXF_RX_DATA;
          end
        end
        UXF_RX_DATA: begin
          if (rx_mid) begin
            rx_sh <= {rxd, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == rx_last) begin
              rx_st <= data_eight ? UXF_RX_STOP : UXF_RX_PAR;
            end
          end
        end
        UXF_RX_PAR: begin
          if (rx_mid) begin
            rx_perr <= rxd != par_bit(rx_sh[7:1], par_mode);
            rx_st <= UXF_RX_STOP;
          end
        end
        default: begin
          if (rx_mid) begin
            rx_ferr <= !rxd;
            if (data_eight) begin
              rx_perr <= 1'b0;
            end
            rx_done <= 1'b1;
            rx_st <= UXF_RX_IDLE;
          end
        end
      endcase
    end
  end

  // Received character decode
  wire is_xoff = sw_flow_en && rx_char == xoff_char;
  wire is_xon = sw_flow_en && rx_char == xon_char;
  wire rx_keep = rx_done && !is_xoff && !is_xon;
  wire rxf_in_ready;
  wire rxf_valid;
  wire [7:0] rxf_data;
  logic remote_off;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      remote_off <= 1'b0;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
      eot_seen <= 1'b0;
    end else begin
      if (rx_done && is_xoff) begin
        remote_off <= 1'b1;
      end else if ((rx_done && is_xon) || !sw_flow_en) begin
        remote_off <= 1'b0;
      end
      parity_err <= rx_done && !data_eight && rx_perr;
      frame_err <= rx_done && rx_ferr;
      eot_seen <= rx_done && rx_char == eot_char;
    end
  end

  uxf_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_rx_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(rx_keep),
    .in_data(rx_char),
    .in_ready(rxf_in_ready),
    .out_valid(rxf_valid),
    .out_data(rxf_data),
    .out_ready(rx_ready && !rx_valid)
  );

  // Receive output stage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else if (rx_valid) begin
      rx_valid <= 1'b0;
    end else if (rxf_valid && rx_ready) begin
      rx_valid <= 1'b1;
      rx_data <= rxf_data;
    end
  end

  // Modem-side flow sequencer
  uxf_fc_type fc_st;
  wire link_up = dtr && dsr && dcd;
  wire want_stop = local_busy || !rxf_in_ready;
  logic fc_send;
  logic [7:0] fc_char;
  logic tx_busy;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fc_st <= UXF_FC_READY;
      rts <= 1'b0;
      dtr <= 1'b0;
      fc_send <= 1'b0;
      fc_char <= '0;
    end else begin
      dtr <= 1'b1;
      fc_send <= 1'b0;
      case (fc_st)
        UXF_FC_READY: begin
          rts <= link_up;
          if (link_up && want_stop) begin
            fc_st <= sw_flow_en ? UXF_FC_SEND_OFF : UXF_FC_DROP;
          end
        end
        UXF_FC_SEND_OFF: begin
          if (!tx_busy && !tx_ready) begin
            fc_send <= 1'b1;
            fc_char <= xoff_char;
            fc_st <= UXF_FC_DROP;
          end
        end
        UXF_FC_DROP: begin
          if (!tx_busy && !fc_send) begin
            rts <= 1'b0;
            fc_st <= UXF_FC_HELD;
          end
        end
        UXF_FC_HELD: begin
          if (!want_stop && link_up) begin
            rts <= 1'b1;
            fc_st <= UXF_FC_WAIT_CTS;
          end
        end
        UXF_FC_WAIT_CTS: begin
          if (cts) begin
            fc_st <= sw_flow_en ? UXF_FC_SEND_ON : UXF_FC_READY;
          end
        end
        default: begin
          if (!tx_busy && !tx_ready) begin
            fc_send <= 1'b1;
            fc_char <= xon_char;
            fc_st <= UXF_FC_READY;
          end
        end
      endcase
    end
  end

  // Transmitter
  uxf_tx_type tx_st;
  logic [3:0] tx_os;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_stop2;
  logic tx_par;
  wire [7:0] tx_load = fc_send ? fc_char : tx_data;
  wire [2:0] tx_last = data_eight ? 3'h7 : 3'h6;
  wire tx_end = tick && tx_os == OVS_LAST;
  wire data_ok = !remote_off && !(hw_flow_en && !cts);
  wire data_go = tx_valid && tx_ready;
  assign tx_busy = tx_st != UXF_TX_IDLE;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st <= UXF_TX_IDLE;
      tx_os <= '0;
      tx_bit <= '0;
      tx_sh <= '0;
      tx_stop2 <= 1'b0;
      tx_par <= 1'b0;
      txd <= 1'b1;
      tx_ready <= 1'b0;
      tx_halted <= 1'b0;
    end else begin
      tx_halted <= !data_ok;
      tx_ready <= 1'b0;
      if (tick) begin
        tx_os <= tx_os + 4'h1;
      end
      case (tx_st)
        UXF_TX_IDLE: begin
          txd <= 1'b1;
          if (fc_send || data_go) begin
            tx_sh <= tx_load;
            tx_par <= par_bit(tx_load[6:0], par_mode);
            tx_st <= UXF_TX_START;
            tx_os <= '0;
            txd <= 1'b0;
          end else begin
            tx_ready <= data_ok && !tx_ready && fc_st != UXF_FC_SEND_OFF
              && fc_st != UXF_FC_SEND_ON;
          end
        end
        UXF_TX_START: begin
          if (tx_end) begin
            tx_bit <= '0;
            txd <= tx_sh[0];
            tx_st <= UXF_TX_DATA;
          end
        end
        UXF_TX_DATA: begin
          if (tx_end) begin
            tx_bit <= tx_bit + 3'h1;
            tx_sh <= {1'b0, tx_sh[7:1]};
            if (tx_bit == tx_last) begin
              tx_stop2 <= stop_two;
              if (data_eight) begin
                txd <= 1'b1;
                tx_st <= UXF_TX_STOP;
              end else begin
                txd <= tx_par;
                tx_st <= UXF_TX_PAR;
              end
            end else begin
              txd <= tx_sh[1];
            end
          end
        end
        UXF_TX_PAR: begin
          if (tx_end) begin
            txd <= 1'b1;
            tx_st <= UXF_TX_STOP;
          end
        end
        default: begin
          if (tx_end) begin
            if (tx_stop2) begin
              tx_stop2 <= 1'b0;
            end else begin
              tx_st <= UXF_TX_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule : uxf_uart

// [core/uxf_pkg.sv]
// How it works
// - One space-level start bit opens each character
// - Seven or eight data bits, LSB first
// - Parity only with seven data bits
// - Even parity makes mark count even
// - Receiver flags parity error on odd count
// - Odd parity makes mark count odd
// - Mark or space parity bit fixed
// - One or two mark-level stop bits close character
// - Receiver resynchronises on each start edge
// - Bad stop bit reports framing error
// - Both ends share rate and format
// - XOFF received halts data transmission
// - XON received resumes transmission
// - End-of-transmission character is flagged
// - Flow control meant for text traffic only
// - When full send XOFF then drop RTS
// - When ready raise RTS, await CTS, send XON
// - RTS exchange needs DTR, DSR and DCD
// - CTS low stops new characters
package uxf_pkg;
  localparam int OVS = 16;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [15:0] DIV_RESET = 16'h0036;
  localparam logic [7:0] XOFF_RESET = 8'h13;
  localparam logic [7:0] XON_RESET = 8'h11;
  localparam logic [7:0] EOT_RESET = 8'h04;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {UXF_PAR_EVEN, UXF_PAR_ODD, UXF_PAR_MARK, UXF_PAR_SPACE} uxf_par_type;
  typedef enum {UXF_TX_IDLE, UXF_TX_START, UXF_TX_DATA, UXF_TX_PAR, UXF_TX_STOP} uxf_tx_type;
  typedef enum {UXF_RX_IDLE, UXF_RX_START, UXF_RX_DATA, UXF_RX_PAR, UXF_RX_STOP} uxf_rx_type;
  typedef enum {UXF_FC_READY, UXF_FC_SEND_OFF, UXF_FC_DROP, UXF_FC_HELD, UXF_FC_WAIT_CTS,
    UXF_FC_SEND_ON} uxf_fc_type;
endpackage : uxf_pkg

// [core/uxf_fifo.sv]
`timescale 1ns/100ps
module uxf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : uxf_fifo

// [verif/uxf_uart_monitor.sv]
`timescale 1ns/100ps
module uxf_uart_monitor (
  // Clock and reset
  input logic mclk,
  input logic arst_n,
  // Watched ports
  input logic [15:0] baud_div,
  input logic data_eight,
  input logic hw_flow_en,
  input logic tx_valid,
  input logic tx_ready,
  input logic rx_ready,
  input logic parity_err,
  input logic frame_err,
  input logic tx_halted,
  input logic local_busy,
  input logic txd,
  input logic dtr,
  input logic rts,
  input logic cts,
  input logic dsr,
  input logic dcd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_start; tx_valid && tx_ready |-> ##2 !txd; endproperty
  a_start: assert property (p_start) else $error("no start bit");
  property p_idle; tx_ready |-> txd; endproperty
  a_idle: assert property (p_idle) else $error("line low at offer");
  property p_bit; $rose(txd) && baud_div == 16'h0000 |-> txd [*8]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short");
  property p_par; parity_err |-> !data_eight; endproperty
  a_par: assert property (p_par) else $error("parity in 8-bit mode");
  property p_halt; tx_halted && $past(tx_halted) |-> !tx_ready; endproperty
  a_halt: assert property (p_halt) else $error("offer while halted");
  property p_cts;
    hw_flow_en && !cts && !$past(cts) && !$past(cts, 2) && !$past(cts, 3) |-> !tx_ready;
  endproperty
  a_cts: assert property (p_cts) else $error("offer while cts low");
  property p_rts_up; $rose(rts) |-> dtr && $past(dsr) && $past(dcd); endproperty
  a_rts_up: assert property (p_rts_up) else $error("rts without link");
  property p_rts_dn; $fell(rts) && dsr && dcd && rx_ready |-> local_busy; endproperty
  a_rts_dn: assert property (p_rts_dn) else $error("rts dropped when idle");
  c_perr: cover property (parity_err);
  c_ferr: cover property (frame_err);
  c_drop: cover property ($fell(rts));
endmodule : uxf_uart_monitor
bind uxf_uart uxf_uart_monitor mon_u (.*);

// [verif/uxf_far_end.sv]
`timescale 1ns/100ps
module uxf_far_end #(
  parameter int BIT = 16
) (
  // Clock
  input logic mclk,
  // Line and modem
  input logic txd,
  input logic rts,
  output logic rxd,
  output logic cts,
  output logic dsr,
  output logic dcd
);
  logic seven = 1'b0;
  logic two = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic cts_hold = 1'b0;
  logic start_cts = 1'b0;
  logic [9:0] got[$];
  int cts_dly = 4;
  int wait_n = 0;
  initial {rxd, cts, dsr, dcd} = 4'hB;
  function automatic logic par_of(input logic [6:0] d);
    par_of = pmode == 2'h0 ? ^d : pmode == 2'h1 ? ~^d : pmode == 2'h2;
  endfunction : par_of
  always @(posedge mclk) begin
    wait_n <= rts ? wait_n + 1 : 0;
    cts <= rts && wait_n >= cts_dly && !cts_hold;
  end
  task automatic send(input logic [7:0] c, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = {2'h3, seven ? {par_of(c[6:0]) ^ bad_par, c[6:0]} : c, 1'b0};
    f[9] = !bad_stop;
    for (int i = 0; i < (two ? 11 : 10); i++) begin
      @(negedge mclk);
      rxd = f[i];
      repeat (BIT - 1) @(negedge mclk);
    end
    rxd = 1'b1;
    repeat (BIT) @(negedge mclk);
  endtask : send
  always begin : watch_txd
    logic [9:0] r;
    @(negedge txd);
    start_cts = cts;
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      r[i] = txd;
      repeat (i < 9 ? BIT : 1) @(posedge mclk);
    end
    got.push_back(r);
  end
endmodule : uxf_far_end

// [verif/uxf_uart_tb.sv]
`timescale 1ns/100ps
module uxf_uart_tb;
  import uxf_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic data_eight = 1'b1;
  uxf_par_type par_mode = UXF_PAR_EVEN;
  logic stop_two = 1'b0;
  logic sw_flow_en = 1'b0;
  logic hw_flow_en = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_ready = 1'b1;
  logic local_busy = 1'b0;
  logic tx_ready, rx_valid, parity_err, frame_err, eot_seen, tx_halted;
  logic txd, rxd, dtr, rts, cts, dsr, dcd;
  logic [7:0] rx_data;
  logic [7:0] rxq[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int n_perr = 0, n_ferr = 0, n_eot = 0, cyc = 0;
  uxf_uart dut_u (.*, .baud_div(16'h0000), .xoff_char(XOFF_RESET), .xon_char(XON_RESET),
    .eot_char(EOT_RESET));
  uxf_far_end far_u (.*);
  always #5 mclk = ~mclk;
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  always @(negedge mclk) begin
    cyc++;
    n_perr += parity_err === 1'b1;
    n_ferr += frame_err === 1'b1;
    n_eot += eot_seen === 1'b1;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (cyc == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [9:0] frm(input logic [7:0] c);
    frm = data_eight ? {1'b1, c, 1'b0} : {1'b1, far_u.par_of(c[6:0]), c[6:0], 1'b0};
  endfunction : frm
  task automatic cfg(input logic e8, input logic [1:0] pm, input logic two);
    data_eight = e8;
    par_mode = uxf_par_type'(pm);
    stop_two = two;
    far_u.seven = !e8;
    far_u.pmode = pm;
    far_u.two = two;
  endtask : cfg
  task automatic tx_one(input logic [7:0] c);
    logic [9:0] e;
    e = frm(c);
    tx_data = c;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    tx_valid = 1'b0;
    while (far_u.got.size() == 0) @(negedge mclk);
    check(far_u.got.pop_front(), e);
  endtask : tx_one
  task automatic stall_tx(input logic [7:0] c, input logic by_cts);
    fork
      tx_one(c);
      begin
        repeat (300) @(negedge mclk);
        check(far_u.got.size(), 0);
        if (by_cts) far_u.cts_hold = 1'b0;
        else far_u.send(XON_RESET, 1'b0, 1'b0);
      end
    join
  endtask : stall_tx
  initial begin
    repeat (12) @(negedge mclk);
    check({txd, rts, dtr, tx_ready}, 4'h8);
    arst_n = 1'b1;
    repeat (10) @(negedge mclk);
    check({dtr, rts}, 2'h3);
    for (int m = 0; m < 5; m++) begin
      cfg(m == 4, m[1:0], m[0]);
      tx_one(8'hB5 + m[7:0]);
    end
    for (int m = 0; m < 4; m++) begin
      cfg(1'b0, m[1:0], 1'b0);
      far_u.send(8'h41, 1'b0, 1'b0);
      far_u.send(8'h41, 1'b1, 1'b0);
    end
    cfg(1'b0, 2'h2, 1'b0);
    far_u.send(EOT_RESET, 1'b0, 1'b0);
    far_u.send(8'h43, 1'b0, 1'b1);
    repeat (300) @(negedge mclk);
    check(n_perr, 4);
    check(n_ferr, 1);
    check(n_eot, 1);
    check(rxq.pop_front(), 8'h41);
    rxq.delete();
    sw_flow_en = 1'b1;
    far_u.send(XOFF_RESET, 1'b0, 1'b0);
    repeat (20) @(negedge mclk);
    check(tx_halted, 1'b1);
    stall_tx(8'h4E, 1'b0);
    check(rxq.size(), 0);
    local_busy = 1'b1;
    while (far_u.got.size() == 0) @(negedge mclk);
    check(far_u.got.pop_front(), frm(XOFF_RESET));
    repeat (40) @(negedge mclk);
    check(rts, 1'b0);
    far_u.cts_dly = 40;
    local_busy = 1'b0;
    while (far_u.got.size() == 0) @(negedge mclk);
    check(far_u.got.pop_front(), frm(XON_RESET));
    check(far_u.start_cts, 1'b1);
    hw_flow_en = 1'b1;
    far_u.cts_hold = 1'b1;
    stall_tx(8'h5A, 1'b1);
    hw_flow_en = 1'b0;
    sw_flow_en = 1'b0;
    cfg(1'b1, 2'h0, 1'b0);
    rx_ready = 1'b0;
    for (int i = 0; i < 8; i++) far_u.send(8'hC0 + i[7:0], 1'b0, 1'b0);
    repeat (300) @(negedge mclk);
    rx_ready = 1'b1;
    repeat (40) @(negedge mclk);
    for (int i = 0; i < 8; i++) check(rxq.pop_front(), 8'hC0 + i[7:0]);
    give_verdict();
  end
endmodule : uxf_uart_tb
